// File: include/dhp_pkg.sv
// Purpose: shared constants and carriers of the disk host control/status port
// Assumes: single 125 MHz card clock, primary host i/o addresses
// Notes:   pin structs carry raw pin levels before synchronisation
package dhp_pkg;

  // host i/o addresses
  localparam logic [9:0] DATA_ADDR  = 10'h1F0;
  localparam logic [9:0] CMD_ADDR   = 10'h1F7;
  localparam logic [9:0] ALT_ADDR   = 10'h3F6;
  localparam logic [9:0] ECHO_ADDR  = 10'h3F7;
  localparam logic [6:0] TASK_BLOCK = 7'h3E;

  // on-card processor codes
  localparam logic [7:0] CP_ERR_CMD = 8'hD7;
  localparam logic [7:0] CP_MULT    = 8'hD6;
  localparam logic [7:0] CP_RLATCH  = 8'hD5;
  localparam logic [7:0] CP_DRQ_IRQ = 8'hD4;
  localparam logic [7:0] CP_CNT_CLR = 8'hD3;
  localparam logic [7:0] CP_SLEEP   = 8'hD2;
  localparam logic [7:0] CP_BUF     = 8'hE0;
  localparam logic [7:0] CP_ECC     = 8'hB0;
  localparam logic [4:0] CP_DC_BLK  = 5'h1C;
  localparam logic [4:0] CP_SA_BLK  = 5'h1D;

  // aux control latch fields
  localparam int AUX_SRST_BIT = 2;
  localparam int AUX_IEN_BIT  = 1;

  // sector stack
  localparam int         WORDS_PER_SECTOR = 256;
  localparam logic [7:0] CNT_LAST         = 8'hFF;
  localparam logic [2:0] ECC_BYTES        = 3'h7;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SRST_MIN_NS   = 10000;
  localparam int SRST_MIN_CYC  = (SRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic        ior_n;
    logic        iow_n;
    logic        aen;
    logic        sbhe_n;
    logic [9:0]  addr;
    logic [15:0] wdata;
    logic        idx;
    logic        rdy;
    logic        seek_done_flag;
    logic        wg_n;
    logic [3:0]  hs_n;
    logic [1:0]  ds_n;
  } dhp_pins_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } dhp_cp_req_s;

  typedef struct packed {
    logic       write_fault_flag;
    logic       corrected_flag;
    logic       err;
    logic       long_mode;
    logic [7:0] fail_sector;
  } dhp_cp_stat_s;

  typedef struct packed {
    logic       dc_cs;
    logic [2:0] dc_reg;
    logic       dc_rd;
    logic       dc_wr;
    logic       sa_cs;
    logic       ecc_cs;
    logic       err_reg_wr;
    logic       cmd_reg_rd;
  } dhp_sel_s;

  typedef struct packed {
    dhp_pins_s   sync1;
    dhp_pins_s   sync2;
    logic        ior_prev;
    logic        iow_prev;
    logic        srst;
    logic        irq_dis;
    logic        irq_lvl;
    logic        transfer_request_flag;
    logic        busy;
    logic        mult;
    logic        rlatch;
    logic        sleep;
    logic        ovf;
    logic [7:0]  cnt;
    logic [2:0]  ecc_cnt;
    logic [15:0] rdata;
    logic [15:0] cp_rdata;
    logic [7:0]  ecc_wdata;
    logic        ecc_rd;
    logic        ecc_wr;
    logic        irq;
    logic        dc_rst_n;
    logic [7:0]  rpt_sector;
  } dhp_state_s;

  localparam dhp_state_s STATE_RESET = '0;

endpackage : dhp_pkg

// File: rtl/dhp_port.sv
// Purpose: host control/status port, sector data stack and processor decode
// Assumes: on-card processor strobes are one-cycle pulses on clk_sys
// Notes:   host pins pass two flip-flops; host strobes act on their leading edge
`timescale 1ns/1ns

// Operation
// (RQ1) alt status mirrors status, bit1 live index
// (RQ2) alt status shows eight controller flags
// (RQ3) index bit follows drive line, unlatched
// (RQ4) alt status read has no side effect
// (RQ5) corrected multi-sector read reports sector plus one
// (RQ6) echo register returns gate, heads, drives
// (RQ7) aux latch: reset bit2, interrupt control bit1
// (RQ8) reset bit holds section logic in reset
// (RQ9) host holds reset bit at least 10 us
// (RQ10) disabling interrupt masks, keeps stored level
// (RQ11) hardware reset clears level, leaves enabled
// (RQ12) data port moves words straight to buffer
// (RQ13) stack of 256 sequential words per sector
// (RQ14) long mode check bytes move as bytes
// (RQ15) irq when level set, enabled, not busy
// (RQ16) command, resets or status read clear level
// (RQ17) processor strobe codes act without data phase
// (RQ18) decode D7, chip selects E1-EF and B0
// (RQ19) multisector busy and request handoff per sector
// (RQ20) counter advances, overflows after 256th word
// (RQ21) host decodes when idle, processor when busy
module dhp_port (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire dhp_pkg::dhp_pins_s    pins,
  input  wire dhp_pkg::dhp_cp_req_s  cp_req,
  input  wire dhp_pkg::dhp_cp_stat_s cp_stat,
  input  wire logic [7:0]            ecc_rdata,
  output logic [15:0]                host_rdata,
  output logic                       host_rdata_oe,
  output logic                       host_cs16_n,
  output logic                       host_irq,
  output dhp_pkg::dhp_sel_s          sel,
  output logic [15:0]                cp_rdata,
  output logic [7:0]                 ecc_wdata,
  output logic                       ecc_byte_rd,
  output logic                       ecc_byte_wr,
  output logic                       buf_ovf,
  output logic                       mult_mode,
  output logic                       read_latch,
  output logic                       sleep_mode,
  output logic                       section_rst_n,
  output logic [7:0]                 rpt_sector
);

  dhp_pkg::dhp_state_s st;
  dhp_pkg::dhp_state_s nx;
  dhp_pkg::dhp_pins_s  s2;

  logic [15:0] sect_mem [dhp_pkg::WORDS_PER_SECTOR];
  logic [15:0] mem_rd;
  logic [15:0] mem_wd;
  logic        mem_we;

  logic       rd_evt;
  logic       wr_evt;
  logic       a_data;
  logic       a_alt;
  logic       a_echo;
  logic       a_cmd;
  logic       a_task;
  logic       word;
  logic       h_word_rd;
  logic       h_word_wr;
  logic       h_ecc_rd;
  logic       h_ecc_wr;
  logic       cp_buf_rd;
  logic       cp_buf_wr;
  logic       advance;
  logic       hclr;
  logic       cp_dc;
  logic [7:0] alt_stat;
  logic [7:0] echo_val;

  assign s2     = st.sync2;
  // leading edge of the synchronised strobe; aen high means dma owns the bus
  assign rd_evt = st.ior_prev & ~s2.ior_n & ~s2.aen;
  assign wr_evt = st.iow_prev & ~s2.iow_n & ~s2.aen;
  assign a_data = (s2.addr == dhp_pkg::DATA_ADDR);
  assign a_alt  = (s2.addr == dhp_pkg::ALT_ADDR);
  assign a_echo = (s2.addr == dhp_pkg::ECHO_ADDR);
  assign a_cmd  = (s2.addr == dhp_pkg::CMD_ADDR);
  assign a_task = (s2.addr[9:3] == dhp_pkg::TASK_BLOCK) && (s2.addr[2:0] != 3'h0);
  assign word   = ~s2.sbhe_n;

  // sector data only as words; check bytes only as bytes in long mode
  assign h_word_rd = rd_evt & a_data & word & ~st.srst;  // [RQ12] [RQ14]
  assign h_word_wr = wr_evt & a_data & word & ~st.srst;  // [RQ12] [RQ14]
  assign h_ecc_rd  = rd_evt & a_data & ~word & cp_stat.long_mode & ~st.srst
                     & (st.ecc_cnt < dhp_pkg::ECC_BYTES);  // [RQ14]
  assign h_ecc_wr  = wr_evt & a_data & ~word & cp_stat.long_mode & ~st.srst
                     & (st.ecc_cnt < dhp_pkg::ECC_BYTES);  // [RQ14]

  // processor buffer access yields to a host word in the same cycle
  assign cp_buf_rd = cp_req.rd & (cp_req.addr == dhp_pkg::CP_BUF) & ~st.srst
                     & ~h_word_rd & ~h_word_wr;
  assign cp_buf_wr = cp_req.wr & (cp_req.addr == dhp_pkg::CP_BUF) & ~st.srst
                     & ~h_word_rd & ~h_word_wr;
  assign advance   = h_word_rd | h_word_wr | cp_buf_rd | cp_buf_wr;  // [RQ13] [RQ20]
  assign hclr      = (wr_evt | rd_evt) & a_cmd;  // [RQ16]

  assign mem_rd = sect_mem[st.cnt];
  assign mem_we = h_word_wr | cp_buf_wr;
  assign mem_wd = h_word_wr ? s2.wdata : cp_req.wdata;

  // no holding register on the write path: the word goes straight into the stack
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
    begin
      sect_mem[st.cnt] <= mem_wd;  // [RQ12] [RQ13]
    end
  end

  // index is taken live from the synchroniser each read, never latched
  assign alt_stat = {st.busy, s2.rdy, cp_stat.write_fault_flag, s2.seek_done_flag,
                     st.transfer_request_flag, cp_stat.corrected_flag, s2.idx, cp_stat.err};  // [RQ1] [RQ2] [RQ3]
  assign echo_val = {1'b0, s2.wg_n, s2.hs_n, s2.ds_n};  // [RQ6]

  always_comb
  begin
    nx          = st;
    nx.sync1    = pins;
    nx.sync2    = st.sync1;
    nx.ior_prev = s2.ior_n;
    nx.iow_prev = s2.iow_n;
    nx.ecc_rd   = 1'b0;
    nx.ecc_wr   = 1'b0;

    if (h_word_rd)
    begin
      nx.rdata = mem_rd;
    end
    if (cp_buf_rd)
    begin
      nx.cp_rdata = mem_rd;
    end
    if (advance)
    begin
      nx.cnt = st.cnt + 8'h01;  // [RQ20]
      if (st.cnt == dhp_pkg::CNT_LAST)
      begin
        nx.ovf     = 1'b1;  // [RQ20]
        nx.ecc_cnt = 3'h0;
        if (st.transfer_request_flag && (h_word_rd || h_word_wr))
        begin
          nx.transfer_request_flag  = 1'b0;  // [RQ19]
          nx.busy = 1'b1;  // [RQ19]
        end
      end
    end
    if (h_ecc_rd)
    begin
      nx.rdata   = {8'h00, ecc_rdata};  // [RQ14]
      nx.ecc_rd  = 1'b1;
      nx.ecc_cnt = st.ecc_cnt + 3'h1;
    end
    if (h_ecc_wr)
    begin
      nx.ecc_wdata = s2.wdata[7:0];  // [RQ14]
      nx.ecc_wr    = 1'b1;
      nx.ecc_cnt   = st.ecc_cnt + 3'h1;
    end
    if (rd_evt && a_alt)
    begin
      nx.rdata = {8'h00, alt_stat};  // [RQ4]
    end
    if (rd_evt && a_echo)
    begin
      nx.rdata = {8'h00, echo_val};  // [RQ6]
    end
    if (wr_evt && a_alt)
    begin
      nx.srst    = s2.wdata[dhp_pkg::AUX_SRST_BIT];  // [RQ7]
      nx.irq_dis = s2.wdata[dhp_pkg::AUX_IEN_BIT];   // [RQ7] [RQ10]
    end
    if (hclr)
    begin
      nx.irq_lvl = 1'b0;  // [RQ16]
    end
    if (wr_evt && a_cmd)
    begin
      nx.busy   = 1'b1;
      nx.sleep  = 1'b0;
      nx.rlatch = 1'b0;
    end

    // processor strobes come after the clears so a coinciding set wins
    if (!st.srst && cp_req.wr)
    begin
      case (cp_req.addr)
        dhp_pkg::CP_MULT:    nx.mult   = 1'b1;  // [RQ17]
        dhp_pkg::CP_RLATCH:  nx.rlatch = 1'b1;  // [RQ17]
        dhp_pkg::CP_DRQ_IRQ:
        begin
          nx.transfer_request_flag  = 1'b1;  // [RQ17] [RQ19]
          nx.busy = 1'b0;  // [RQ19]
        end
        default:             nx.mult   = nx.mult;
      endcase
    end
    if (!st.srst && cp_req.rd)
    begin
      case (cp_req.addr)
        dhp_pkg::CP_MULT:    nx.mult    = 1'b0;  // [RQ17]
        dhp_pkg::CP_DRQ_IRQ: nx.irq_lvl = 1'b1;  // [RQ17] [RQ19]
        dhp_pkg::CP_CNT_CLR:
        begin
          nx.cnt     = 8'h00;  // [RQ17]
          // an overflow landing in the same cycle as the clear still wins
          nx.ovf     = advance & (st.cnt == dhp_pkg::CNT_LAST);
          nx.ecc_cnt = 3'h0;
        end
        dhp_pkg::CP_SLEEP:
        begin
          nx.sleep = 1'b1;  // [RQ17]
          nx.busy  = 1'b0;
        end
        default:             nx.mult    = nx.mult;
      endcase
    end

    // programmed reset: section logic held cleared; aux latch itself survives
    if (st.srst)
    begin
      nx.irq_lvl = 1'b0;  // [RQ8] [RQ16]
      nx.transfer_request_flag     = 1'b0;  // [RQ8]
      nx.busy    = 1'b0;
      nx.mult    = 1'b0;
      nx.rlatch  = 1'b0;
      nx.sleep   = 1'b0;
      nx.ovf     = 1'b0;
      nx.cnt     = 8'h00;
      nx.ecc_cnt = 3'h0;
    end

    // disable only masks; the stored level is untouched
    nx.irq        = nx.irq_lvl & ~nx.irq_dis & ~nx.busy;  // [RQ10] [RQ15]
    nx.dc_rst_n   = ~nx.srst;  // [RQ8]
    nx.rpt_sector = cp_stat.fail_sector
                    + {7'h00, nx.mult & nx.rlatch & cp_stat.corrected_flag};  // [RQ5]
  end

  // hardware reset clears the level and leaves irq_dis low, i.e. enabled
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= dhp_pkg::STATE_RESET;  // [RQ11]
    end
    else
    begin
      st <= nx;
    end
  end

  // register decode owner switches with busy
  assign cp_dc = (cp_req.addr[7:3] == dhp_pkg::CP_DC_BLK) && (cp_req.addr[2:0] != 3'h0);

  always_comb
  begin
    if (!st.busy)
    begin
      sel.dc_cs  = a_task & (rd_evt | wr_evt);  // [RQ21]
      sel.dc_reg = s2.addr[2:0];
      sel.dc_rd  = a_task & rd_evt;
      sel.dc_wr  = a_task & wr_evt;
    end
    else
    begin
      sel.dc_cs  = cp_dc & (cp_req.rd | cp_req.wr);  // [RQ18] [RQ21]
      sel.dc_reg = cp_req.addr[2:0];
      sel.dc_rd  = cp_dc & cp_req.rd;
      sel.dc_wr  = cp_dc & cp_req.wr;
    end
    sel.sa_cs      = (cp_req.addr[7:3] == dhp_pkg::CP_SA_BLK) & (cp_req.rd | cp_req.wr);  // [RQ18]
    sel.ecc_cs     = (cp_req.addr == dhp_pkg::CP_ECC) & (cp_req.rd | cp_req.wr);  // [RQ18]
    sel.err_reg_wr = (cp_req.addr == dhp_pkg::CP_ERR_CMD) & cp_req.wr;  // [RQ18]
    sel.cmd_reg_rd = (cp_req.addr == dhp_pkg::CP_ERR_CMD) & cp_req.rd;  // [RQ18]
  end

  assign host_rdata    = st.rdata;
  assign host_rdata_oe = ~s2.ior_n & ~s2.aen & (a_data | a_alt | a_echo);
  assign host_cs16_n   = ~(a_data & ~s2.aen & ~(cp_stat.long_mode & s2.sbhe_n));
  assign host_irq      = st.irq;
  assign cp_rdata      = st.cp_rdata;
  assign ecc_wdata     = st.ecc_wdata;
  assign ecc_byte_rd   = st.ecc_rd;
  assign ecc_byte_wr   = st.ecc_wr;
  assign buf_ovf       = st.ovf;
  assign mult_mode     = st.mult;
  assign read_latch    = st.rlatch;
  assign sleep_mode    = st.sleep;
  assign section_rst_n = st.dc_rst_n;
  assign rpt_sector    = st.rpt_sector;

  // helper for the soft reset length cover only
  logic [10:0] srst_cyc;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srst_cyc <= 11'h000;
    end
    else if (!st.srst)
    begin
      srst_cyc <= 11'h000;
    end
    else if (srst_cyc != 11'h7FF)
    begin
      srst_cyc <= srst_cyc + 11'h001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  alt_index_a: assert property (rd_evt && a_alt |=> st.rdata[1] == $past(s2.idx))  // [RQ1] [RQ3]
    else $error("alt status bit1 is not the live index");
  alt_busy_a: assert property (rd_evt && a_alt  // [RQ2]
      |=> st.rdata[7:3] ==
      {$past(st.busy), $past(s2.rdy), $past(cp_stat.write_fault_flag), $past(s2.seek_done_flag), $past(st.transfer_request_flag)})
    else $error("alt status flags wrong");
  alt_noeffect_a: assert property (rd_evt && a_alt && !cp_req.rd && !cp_req.wr  // [RQ4]
      && !st.srst |=> st.irq_lvl == $past(st.irq_lvl) && st.cnt == $past(st.cnt))
    else $error("alt status read disturbed state");
  echo_map_a: assert property (rd_evt && a_echo  // [RQ6]
      |=> st.rdata[7:0] == {1'b0, $past(s2.wg_n), $past(s2.hs_n), $past(s2.ds_n)})
    else $error("echo register mapping wrong");
  srst_hold_a: assert property (st.srst |=> !st.transfer_request_flag && st.cnt == 8'h00 && !st.irq_lvl)  // [RQ8]
    else $error("section not held in reset");
  mask_keep_a: assert property (st.irq_dis && st.irq_lvl && !hclr && !st.srst  // [RQ10]
      && !(wr_evt && a_alt) |=> st.irq_lvl && !st.irq)
    else $error("masking lost the stored level");
  irq_gate_a: assert property (st.irq == (st.irq_lvl && !st.irq_dis && !st.busy))  // [RQ15]
    else $error("irq output not gated correctly");
  irq_clear_a: assert property (hclr  // [RQ16]
      && !(cp_req.rd && cp_req.addr == dhp_pkg::CP_DRQ_IRQ) |=> !st.irq_lvl)
    else $error("host command did not clear level");
  mult_set_a: assert property (cp_req.wr && cp_req.addr == dhp_pkg::CP_MULT  // [RQ17]
      && !st.srst |=> st.mult ##1 (st.mult || $past(cp_req.rd) || $past(st.srst)))
    else $error("multiple mode strobe ignored");
  drain_a: assert property ((h_word_rd || h_word_wr) && st.transfer_request_flag  // [RQ19] [RQ20]
      && st.cnt == dhp_pkg::CNT_LAST && !cp_req.rd && !cp_req.wr
      |=> !st.transfer_request_flag && st.busy && st.ovf && st.cnt == 8'h00)
    else $error("sector drain handoff wrong");
  advance_a: assert property (advance && !cp_req.rd |=> st.cnt == $past(st.cnt) + 8'h01)  // [RQ13]
    else $error("stack address did not advance");

  sector_done_c: cover property (st.transfer_request_flag ##1 !st.transfer_request_flag && st.busy);
  irq_fire_c:    cover property (!st.irq ##1 st.irq);
  srst_len_c:    cover property (st.srst && srst_cyc == 11'(dhp_pkg::SRST_MIN_CYC));
  ecc_byte_c:    cover property (h_ecc_rd || h_ecc_wr);

endmodule : dhp_port

// File: testbench/dhp_host_model.sv
// Purpose: host processor model on the i/o bus side of the disk port
// Assumes: strobes change on falling clk_sys edges
// Notes:   four cycles low and four high per access, wider than the synchroniser needs
`timescale 1ns/1ns
module dhp_host_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] rdata,
  input  wire logic        rdata_oe,
  input  wire logic        cs16_n,
  output logic             ior_n,
  output logic             iow_n,
  output logic             sbhe_n,
  output logic [9:0]       addr,
  output logic [15:0]      wdata
);
  logic [15:0] rd_q;
  logic [1:0]  flag_q;

  initial
  begin
    ior_n  = 1'b1;
    iow_n  = 1'b1;
    sbhe_n = 1'b1;
    addr   = 10'h000;
    wdata  = 16'h0000;
    rd_q   = 16'h0000;
    flag_q = 2'b00;
  end

  // w high writes, byt high makes a byte access
  task automatic io(input logic w, input logic [9:0] a, input logic [15:0] d, input logic byt);
    @(negedge clk_sys);
    addr   = a;
    wdata  = d;
    sbhe_n = byt;
    ior_n  = w;
    iow_n  = !w;
    repeat (4) @(negedge clk_sys);
    rd_q  = rdata;
    // output enable and word select, both settled while the strobe stands
    flag_q = {rdata_oe, cs16_n};
    ior_n = 1'b1;
    iow_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    // released data bus must not look like a held copy
    wdata = ~d;
  endtask : io
endmodule : dhp_host_model

// File: testbench/tb.sv
// Purpose: self-checking bench of the disk host control/status port
// Assumes: inputs change on falling edges, host model paces its own strobes
// Notes:   one whole sector from processor to host, then a four-word run from host to processor
`timescale 1ns/1ns
module tb;
  logic                  clk_sys;
  logic                  rst_n;
  logic                  h_ior_n;
  logic                  h_iow_n;
  logic                  h_sbhe_n;
  logic [9:0]            h_addr;
  logic [15:0]           h_wdata;
  logic                  idx;
  logic                  rdy;
  logic                  seek_done_flag;
  logic                  wg_n;
  logic [3:0]            hs_n;
  logic [1:0]            ds_n;
  dhp_pkg::dhp_pins_s    pins;
  dhp_pkg::dhp_cp_req_s  cp_req;
  dhp_pkg::dhp_cp_stat_s cp_stat;
  dhp_pkg::dhp_sel_s     sel;
  dhp_pkg::dhp_sel_s     sel_q;
  logic [7:0]            ecc_rdata;
  logic [15:0]           host_rdata;
  logic                  host_rdata_oe;
  logic                  host_cs16_n;
  logic [7:0]            ecc_wdata;
  logic                  ecc_byte_rd;
  logic                  ecc_byte_wr;
  logic                  host_irq;
  logic [15:0]           cp_rdata;
  logic                  buf_ovf;
  logic                  mult_mode;
  logic                  read_latch;
  logic                  sleep_mode;
  logic                  section_rst_n;
  logic [7:0]            rpt_sector;
  int                    mismatches;
  int                    cmp_count;
  int                    cyc;
  int                    ecc_evt;

  // aen held low: dma cycles are outside this bench
  assign pins = {h_ior_n, h_iow_n, 1'b0, h_sbhe_n, h_addr, h_wdata,
                 idx, rdy, seek_done_flag, wg_n, hs_n, ds_n};

  dhp_host_model host_i (
    .clk_sys  (clk_sys),
    .rdata    (host_rdata),
    .rdata_oe (host_rdata_oe),
    .cs16_n   (host_cs16_n),
    .ior_n    (h_ior_n),
    .iow_n    (h_iow_n),
    .sbhe_n   (h_sbhe_n),
    .addr     (h_addr),
    .wdata    (h_wdata)
  );

  dhp_port dhp_port_i (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .pins          (pins),
    .cp_req        (cp_req),
    .cp_stat       (cp_stat),
    .ecc_rdata     (ecc_rdata),
    .host_rdata    (host_rdata),
    .host_rdata_oe (host_rdata_oe),
    .host_cs16_n   (host_cs16_n),
    .host_irq      (host_irq),
    .sel           (sel),
    .cp_rdata      (cp_rdata),
    .ecc_wdata     (ecc_wdata),
    .ecc_byte_rd   (ecc_byte_rd),
    .ecc_byte_wr   (ecc_byte_wr),
    .buf_ovf       (buf_ovf),
    .mult_mode     (mult_mode),
    .read_latch    (read_latch),
    .sleep_mode    (sleep_mode),
    .section_rst_n (section_rst_n),
    .rpt_sector    (rpt_sector)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // check-byte strobes last one cycle, so each is seen at exactly one falling edge
  always @(negedge clk_sys)
  begin
    if (ecc_byte_rd || ecc_byte_wr)
      ecc_evt++;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // sel is combinational, so it is caught in the request cycle
  task automatic cp(input logic r, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    cp_req = '{addr: a, rd: r, wr: !r, wdata: d};
    #1 sel_q = sel;
    @(negedge clk_sys);
    cp_req.rd = 1'b0;
    cp_req.wr = 1'b0;
  endtask : cp

  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    host_i.io(1'b0, a, 16'h0000, 1'b1);
    chk({8'h00, host_i.rd_q[7:0]}, {8'h00, e});
  endtask : rchk

  task automatic hw_reset;
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask : hw_reset

  initial
  begin
    mismatches = 0;
    cmp_count  = 0;
    cyc        = 0;
    ecc_evt    = 0;
    rst_n      = 1'b0;
    {idx, rdy, seek_done_flag, wg_n, hs_n, ds_n} = {3'b011, 1'b0, 4'hA, 2'h1};
    cp_req     = '0;
    cp_stat    = '0;
    ecc_rdata  = 8'h5C;
    hw_reset();
    rchk(dhp_pkg::ALT_ADDR, 8'h50);
    chk(16'(host_i.flag_q), 16'h0003);
    idx = 1'b1;
    rchk(dhp_pkg::ALT_ADDR, 8'h52);
    idx = 1'b0;
    cp_stat.write_fault_flag = 1'b1;
    cp_stat.err = 1'b1;
    rchk(dhp_pkg::ALT_ADDR, 8'h71);
    cp_stat = '0;
    rchk(dhp_pkg::ECHO_ADDR, 8'h29);
    cp(1'b0, dhp_pkg::CP_DRQ_IRQ, 16'h0000);
    cp(1'b1, dhp_pkg::CP_DRQ_IRQ, 16'h0000);
    chk(16'(host_irq), 16'h0001);
    host_i.io(1'b1, dhp_pkg::ALT_ADDR, 16'h0002, 1'b1);
    chk(16'(host_irq), 16'h0000);
    rchk(dhp_pkg::ALT_ADDR, 8'h58);
    host_i.io(1'b1, dhp_pkg::ALT_ADDR, 16'h0000, 1'b1);
    chk(16'(host_irq), 16'h0001);
    host_i.io(1'b0, dhp_pkg::CMD_ADDR, 16'h0000, 1'b1);
    chk(16'(host_irq), 16'h0000);
    // fill a sector from the processor side, then drain it from the host
    for (int i = 0; i < dhp_pkg::WORDS_PER_SECTOR; i++)
      cp(1'b0, dhp_pkg::CP_BUF, 16'(i) ^ 16'hA5C3);
    cp(1'b1, dhp_pkg::CP_CNT_CLR, 16'h0000);
    chk(16'(buf_ovf), 16'h0000);
    for (int i = 0; i < dhp_pkg::WORDS_PER_SECTOR; i++)
    begin
      if (i == dhp_pkg::WORDS_PER_SECTOR - 1)
        chk(16'(buf_ovf), 16'h0000);
      host_i.io(1'b0, dhp_pkg::DATA_ADDR, 16'h0000, 1'b0);
      chk(host_i.rd_q, 16'(i) ^ 16'hA5C3);
      chk(16'(host_i.flag_q), 16'h0002);
    end
    chk(16'(buf_ovf), 16'h0001);
    rchk(dhp_pkg::ALT_ADDR, 8'hD0);
    // busy now: decode belongs to the processor
    cp(1'b0, 8'hE3, 16'h0000);
    chk(16'(sel_q.dc_cs), 16'h0001);
    cp(1'b0, dhp_pkg::CP_ERR_CMD, 16'h0000);
    chk(16'(sel_q.err_reg_wr), 16'h0001);
    cp(1'b1, dhp_pkg::CP_ERR_CMD, 16'h0000);
    chk(16'(sel_q.cmd_reg_rd), 16'h0001);
    cp(1'b0, 8'hE9, 16'h0000);
    chk({14'h0, sel_q.sa_cs, sel_q.dc_cs}, 16'h0002);
    cp(1'b1, dhp_pkg::CP_ECC, 16'h0000);
    chk(16'(sel_q.ecc_cs), 16'h0001);
    cp(1'b1, dhp_pkg::CP_CNT_CLR, 16'h0000);
    for (int i = 0; i < 4; i++)
      host_i.io(1'b1, dhp_pkg::DATA_ADDR, 16'h3C00 + 16'(i), 1'b0);
    cp(1'b1, dhp_pkg::CP_CNT_CLR, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      cp(1'b1, dhp_pkg::CP_BUF, 16'h0000);
      chk(cp_rdata, 16'h3C00 + 16'(i));
    end
    cp_stat.corrected_flag         = 1'b1;
    cp_stat.fail_sector = 8'h21;
    cp(1'b0, dhp_pkg::CP_MULT, 16'h0000);
    cp(1'b0, dhp_pkg::CP_RLATCH, 16'h0000);
    chk({mult_mode, read_latch, 6'h00, rpt_sector}, 16'hC022);
    cp(1'b1, dhp_pkg::CP_MULT, 16'h0000);
    chk({mult_mode, 7'h00, rpt_sector}, 16'h0021);
    cp(1'b1, dhp_pkg::CP_SLEEP, 16'h0000);
    chk(16'(sleep_mode), 16'h0001);
    host_i.io(1'b1, dhp_pkg::CMD_ADDR, 16'h0020, 1'b1);
    chk({14'h0, sleep_mode, read_latch}, 16'h0000);
    cp_stat.long_mode = 1'b1;
    host_i.io(1'b0, dhp_pkg::DATA_ADDR, 16'h0000, 1'b1);
    chk({8'h00, host_i.rd_q[7:0]}, 16'h005C);
    chk(16'(host_i.flag_q), 16'h0003);
    host_i.io(1'b1, dhp_pkg::DATA_ADDR, 16'h00A7, 1'b1);
    chk({ecc_wdata, 8'(ecc_evt)}, 16'hA702);
    chk(16'(host_i.flag_q), 16'h0001);
    cp_stat = '0;
    cp(1'b0, dhp_pkg::CP_MULT, 16'h0000);
    host_i.io(1'b1, dhp_pkg::ALT_ADDR, 16'h0004, 1'b1);
    chk({14'h0, section_rst_n, mult_mode}, 16'h0000);
    repeat (dhp_pkg::SRST_MIN_CYC) @(negedge clk_sys);
    cp(1'b0, dhp_pkg::CP_MULT, 16'h0000);
    chk({14'h0, section_rst_n, mult_mode}, 16'h0000);
    host_i.io(1'b1, dhp_pkg::ALT_ADDR, 16'h0000, 1'b1);
    chk(16'(section_rst_n), 16'h0001);
    host_i.io(1'b1, dhp_pkg::ALT_ADDR, 16'h0002, 1'b1);
    hw_reset();
    cp(1'b0, dhp_pkg::CP_DRQ_IRQ, 16'h0000);
    chk(16'(host_irq), 16'h0000);
    cp(1'b1, dhp_pkg::CP_DRQ_IRQ, 16'h0000);
    chk(16'(host_irq), 16'h0001);
    end_sim();
  end
endmodule : tb
